// >>> dv/asf_dev_model.sv
// Behavioural strobe FIFO device facing the host controller
`timescale 1ns/1ps
module asf_dev_model #(
  parameter int DEPTH = 8
) (
  input wire logic wr_strobe_n,
  input wire logic rd_strobe_n,
  input wire logic init_pulse_n,
  input wire logic rewind_pulse_n,
  input wire logic lead_device_select_n,
  input wire logic chain_in_n,
  input wire logic [8:0] data_in,
  output logic [8:0] output_bus,
  output logic empty_flag_n,
  output logic full_flag_n,
  output logic half_full_flag_n
);
  logic [8:0] mem [DEPTH];
  logic [8:0] word_q = 9'h000;
  logic wr_ok = 1'b0;
  logic rd_ok = 1'b0;
  int wp = 0;
  int rp = 0;
  int cnt = 0;
  // ==========================================================
  // Pointers
  // Lead select ignored: init clears the same way either way
  always @(negedge init_pulse_n) begin
    wp = 0;
    rp = 0;
    cnt = 0;
  end
  always @(negedge rewind_pulse_n) begin
    if (!chain_in_n) begin
      rp = 0;
      cnt = wp;
    end
  end
  always @(negedge wr_strobe_n) begin
    wr_ok = (cnt < DEPTH);
  end
  always @(posedge wr_strobe_n) begin
    if (wr_ok) begin
      mem[wp] = data_in;
      wp = (wp + 1) % DEPTH;
      cnt = cnt + 1;
    end
  end
  always @(negedge rd_strobe_n) begin
    rd_ok = (cnt != 0);
    if (rd_ok) begin
      word_q = mem[rp];
      rp = (rp + 1) % DEPTH;
      cnt = cnt - 1;
    end
  end
  // ==========================================================
  // Outputs
  // Released bus shows junk, so a late sample cannot pass
  assign output_bus = (!rd_strobe_n && rd_ok) ? word_q : ~word_q;
  // Flow-through pulses collapse to plain levels; flags settle after init
  assign empty_flag_n = (cnt != 0);
  assign full_flag_n = (cnt != DEPTH);
  // Single device only: no chain pulse is produced
  assign half_full_flag_n = chain_in_n | (cnt <= DEPTH / 2);
endmodule

// >>> dv/tb.sv
// Self-checking bench for the strobe FIFO host controller
`timescale 1ns/1ps
module tb import asf_pkg::*;;
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, v;
  logic wr_n, rd_n, init_n, rew_n, lead_n, chain_n, ef_n, ff_n, hf_n;
  logic [8:0] din, qbus;
  int miscompares = 0;
  int checked = 0;
  int nwr = 0;
  int nrew = 0;
  asf_host dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .wr_strobe_n(wr_n),
    .rd_strobe_n(rd_n), .init_pulse_n(init_n), .rewind_pulse_n(rew_n),
    .lead_device_select_n(lead_n), .chain_in_n(chain_n), .data_in(din),
    .output_bus(qbus), .empty_flag_n(ef_n), .full_flag_n(ff_n),
    .half_full_flag_n(hf_n));
  asf_dev_model #(.DEPTH(8)) dev (.wr_strobe_n(wr_n), .rd_strobe_n(rd_n),
    .init_pulse_n(init_n), .rewind_pulse_n(rew_n),
    .lead_device_select_n(lead_n), .chain_in_n(chain_n), .data_in(din),
    .output_bus(qbus), .empty_flag_n(ef_n), .full_flag_n(ff_n),
    .half_full_flag_n(hf_n));
  // ==========================================================
  // Pin watch
  always @(negedge wr_n) nwr++;
  always @(negedge rew_n) nrew++;
  always @(negedge clk) begin
    if ((!wr_n || !rd_n) && (!init_n || !rew_n)) begin
      miscompares++;
      $display("FAIL strobe_during_init expected 1 seen 0");
    end
  end
  // ==========================================================
  // Bus tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [1:0] r,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= {r, 2'h0};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(negedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 300);
    if (n >= 300) chk("bus_timeout", 32'h0, 32'h1);
    @(posedge clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [1:0] r, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, r, d, x);
  endtask
  task automatic st(input logic [4:0] e, input string n);
    logic [31:0] s;
    bus(1'b0, REG_STATUS, 32'h0, s);
    chk(n, {27'h0, e}, s & 32'h1f);
  endtask
  task automatic pop(input logic [8:0] e, input string n);
    logic [31:0] s;
    bus(1'b0, REG_DATA, 32'h0, s);
    chk(n, {23'h0, e}, s);
  endtask
  task automatic init_dev();
    wr(REG_STATUS, 32'h8);
    wr(REG_CMD, 32'h1);
    st(5'h16, "status_after_init");
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk("pins_idle", 32'h1e, {27'h0, wr_n, rd_n, init_n, rew_n, chain_n});
    wr(REG_DATA, 32'h055);
    chk("unsettled_no_strobe", 0, nwr);
    st(5'h0e, "status_unsettled");
  endtask
  task automatic t_rewind();
    init_dev();
    for (int i = 0; i < 3; i++) wr(REG_DATA, 32'h100 + i);
    pop(9'h100, "first_word");
    pop(9'h101, "second_word");
    wr(REG_CMD, 32'h2);
    chk("rewind_pulsed", 1, nrew);
    pop(9'h100, "word_after_rewind");
  endtask
  task automatic t_fill();
    init_dev();
    for (int i = 0; i < 8; i++) begin
      wr(REG_DATA, 32'h0a0 + i);
      if (i == 3) st(5'h17, "status_half_minus");
      if (i == 4) st(5'h13, "status_half_plus");
    end
    st(5'h11, "status_full");
    wr(REG_DATA, 32'h1ff);
    chk("full_no_strobe", 9 + 8, nwr);
    st(5'h19, "status_full_refused");
    pop(9'h0a0, "pop_from_full");
    pop(9'h0a1, "pop_second");
    wr(REG_DATA, 32'h0c0);
    wr(REG_DATA, 32'h0c1);
    for (int i = 2; i < 8; i++) pop(9'h0a0 + 9'(i), "pop_order");
    pop(9'h0c0, "pop_wrapped");
    pop(9'h0c1, "pop_wrapped");
    pop(9'h000, "pop_empty_refused");
    st(5'h1e, "status_empty_refused");
  endtask
  task automatic t_depth();
    wr(REG_CFG, 32'h3);
    bus(1'b0, REG_CFG, 32'h0, v);
    chk("cfg_readback", 32'h3, v & 32'h3);
    chk("depth_pins", 32'h2, {30'h0, chain_n, lead_n});
    wr(REG_STATUS, 32'h8);
    wr(REG_CMD, 32'h2);
    chk("depth_no_rewind", 1, nrew);
    st(5'h1e, "status_depth_refused");
  endtask
  // ==========================================================
  // Run control
  task automatic end_of_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #(4 * 20000);
    miscompares++;
    end_of_test();
  end
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_rewind();
    nwr = 9;
    t_fill();
    t_depth();
    end_of_test();
  end
endmodule

// >>> verilog/asf_host.sv
// Host controller driving a strobe-operated FIFO through its pins
`timescale 1ns/1ps

// How it works
// - Host keeps write and read strobes high around init release.
// - Single mode is chosen by driving the chain input low.
// - Only the lead device gets lead select low; set by config.
// - Chain output to next chain input is board wiring.
// - Composite flags are ORed externally across cascaded devices.
// - Width expansion shares controls; flags from any one device.
// - Host strobes a write only while the full flag is high.
// - Host watches full before writing and empty before reading.
// - Host keeps both strobes high while rewind is low.
module asf_host import asf_pkg::*; (
  clk,
  rst_n,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_readdata,
  avs_waitrequest,
  wr_strobe_n,
  rd_strobe_n,
  init_pulse_n,
  rewind_pulse_n,
  lead_device_select_n,
  chain_in_n,
  data_in,
  output_bus,
  empty_flag_n,
  full_flag_n,
  half_full_flag_n
);
  input wire logic clk;
  input wire logic rst_n;
  input wire logic [ADDR_W-1:0] avs_address;
  input wire logic avs_read;
  input wire logic avs_write;
  input wire logic [31:0] avs_writedata;
  output logic [31:0] avs_readdata;
  output logic avs_waitrequest;
  output logic wr_strobe_n;
  output logic rd_strobe_n;
  output logic init_pulse_n;
  output logic rewind_pulse_n;
  output logic lead_device_select_n;
  output logic chain_in_n;
  output logic [WORD_W-1:0] data_in;
  input wire logic [WORD_W-1:0] output_bus;
  input wire logic empty_flag_n;
  input wire logic full_flag_n;
  input wire logic half_full_flag_n;

  typedef struct packed {
    asf_state_e state;
    logic [15:0] cnt;
    logic waitreq;
    logic [31:0] rdata;
    logic wr_n;
    logic rd_n;
    logic init_n;
    logic rt_n;
    logic [WORD_W-1:0] din;
    logic depth;
    logic lead;
    logic refused;
    logic settled;
  } asf_host_s;

  asf_host_s st_q;
  asf_host_s st_d;

  logic [WORD_W+FLAG_W-1:0] pins_s;
  logic [WORD_W-1:0] bus_s;
  logic empty_s;
  logic full_s;
  logic half_s;

  // ==========================================================
  // Pin synchronisers
  asf_sync #(.W(WORD_W + FLAG_W)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din({output_bus, half_full_flag_n, full_flag_n, empty_flag_n}),
    .dout(pins_s)
  );

  assign empty_s = pins_s[ST_EMPTY];
  assign full_s = pins_s[ST_FULL];
  assign half_s = pins_s[ST_HALF];
  assign bus_s = pins_s[WORD_W+FLAG_W-1:FLAG_W];

  function automatic logic [31:0] status_word(input asf_host_s s,
                                              input logic e, input logic f,
                                              input logic h);
    logic [31:0] w;
    w = '0;
    w[ST_EMPTY] = e;
    w[ST_FULL] = f;
    w[ST_HALF] = h;
    w[ST_REFUSED] = s.refused;
    w[ST_SETTLED] = s.settled;
    return w;
  endfunction

  // ==========================================================
  // Sequencer; waitrequest stays high until the pin cycle is done
  always_comb begin
    st_d = st_q;
    st_d.waitreq = 1'b1;
    case (st_q.state)
      S_IDLE: begin
        if (avs_write) begin
          case (avs_address[3:2])
            REG_CFG: begin
              st_d.depth = avs_writedata[CFG_DEPTH];
              st_d.lead = avs_writedata[CFG_LEAD];
              st_d.state = S_ACK;
            end
            REG_STATUS: begin
              if (avs_writedata[ST_REFUSED]) st_d.refused = 1'b0;
              st_d.state = S_ACK;
            end
            REG_CMD: begin
              st_d.cnt = '0;
              if (avs_writedata[CMD_INIT]) begin
                st_d.init_n = 1'b0;
                st_d.settled = 1'b0;
                st_d.state = S_INIT;
              end else if (avs_writedata[CMD_REWIND] && !st_q.depth &&
                           st_q.settled) begin
                st_d.rt_n = 1'b0;
                st_d.state = S_REWIND;
              end else begin
                if (avs_writedata[CMD_REWIND]) st_d.refused = 1'b1;
                st_d.state = S_ACK;
              end
            end
            default: begin
              // Write only while not full, and not before settling
              if (full_s && st_q.settled) begin
                st_d.din = avs_writedata[WORD_W-1:0];
                st_d.wr_n = 1'b0;
                st_d.cnt = '0;
                st_d.state = S_WLOW;
              end else begin
                st_d.refused = 1'b1;
                st_d.state = S_ACK;
              end
            end
          endcase
        end else if (avs_read) begin
          st_d.rdata = '0;
          case (avs_address[3:2])
            REG_CFG: begin
              st_d.rdata[CFG_DEPTH] = st_q.depth;
              st_d.rdata[CFG_LEAD] = st_q.lead;
              st_d.state = S_ACK;
            end
            REG_STATUS: begin
              // Half-full only means something in single mode
              st_d.rdata = status_word(st_q, empty_s, full_s,
                                       half_s | st_q.depth);
              st_d.state = S_ACK;
            end
            REG_DATA: begin
              if (empty_s && st_q.settled) begin
                st_d.rd_n = 1'b0;
                st_d.cnt = '0;
                st_d.state = S_RLOW;
              end else begin
                st_d.refused = 1'b1;
                st_d.state = S_ACK;
              end
            end
            default: st_d.state = S_ACK;
          endcase
        end
      end
      S_WLOW: begin
        st_d.cnt = st_q.cnt + 16'h0001;
        if (st_q.cnt == CYC_STROBE - 16'h0001) begin
          st_d.wr_n = 1'b1;
          st_d.cnt = '0;
          st_d.state = S_REC;
        end
      end
      S_RLOW: begin
        // Bus is driven only while read strobe low; sample before rising
        st_d.cnt = st_q.cnt + 16'h0001;
        if (st_q.cnt == CYC_STROBE + 16'(SYNC_LAT) - 16'h0001) begin
          st_d.rdata = 32'(bus_s);
          st_d.rd_n = 1'b1;
          st_d.cnt = '0;
          st_d.state = S_REC;
        end
      end
      S_INIT: begin
        st_d.cnt = st_q.cnt + 16'h0001;
        if (st_q.cnt == CYC_INIT - 16'h0001) begin
          st_d.init_n = 1'b1;
          st_d.cnt = '0;
          st_d.state = S_SETTLE;
        end
      end
      S_REWIND: begin
        st_d.cnt = st_q.cnt + 16'h0001;
        if (st_q.cnt == CYC_INIT - 16'h0001) begin
          st_d.rt_n = 1'b1;
          st_d.cnt = '0;
          st_d.state = S_SETTLE;
        end
      end
      S_REC: begin
        // Flags must travel through the device and the synchroniser
        st_d.cnt = st_q.cnt + 16'h0001;
        if (st_q.cnt == CYC_RECOVER - 16'h0001) begin
          st_d.waitreq = 1'b0;
          st_d.state = S_ACK;
        end
      end
      S_SETTLE: begin
        st_d.cnt = st_q.cnt + 16'h0001;
        if (st_q.cnt == CYC_SETTLE - 16'h0001) begin
          st_d.settled = 1'b1;
          st_d.waitreq = 1'b0;
          st_d.state = S_ACK;
        end
      end
      S_ACK: begin
        // Fast registers answer here; pin cycles answered one earlier
        if (st_q.waitreq) begin
          st_d.waitreq = 1'b0;
        end else begin
          st_d.state = S_IDLE;
        end
      end
      default: st_d.state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{state: S_IDLE, cnt: '0, waitreq: 1'b1, rdata: '0,
                wr_n: 1'b1, rd_n: 1'b1, init_n: 1'b1, rt_n: 1'b1,
                din: '0, depth: 1'b0, lead: 1'b0, refused: 1'b0,
                settled: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Pin and bus outputs
  assign avs_readdata = st_q.rdata;
  assign avs_waitrequest = st_q.waitreq;
  assign wr_strobe_n = st_q.wr_n;
  assign rd_strobe_n = st_q.rd_n;
  assign init_pulse_n = st_q.init_n;
  assign rewind_pulse_n = st_q.rt_n;
  assign lead_device_select_n = !st_q.lead;
  // Cascade wiring and flag ORing live on the board
  assign chain_in_n = st_q.depth;
  assign data_in = st_q.din;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  init_strobes_a: assert property (
    !st_q.init_n |-> st_q.wr_n && st_q.rd_n ##1 st_q.wr_n && st_q.rd_n)
    else $error("strobe low around init");
  rewind_strobes_a: assert property (
    !st_q.rt_n |-> st_q.wr_n && st_q.rd_n)
    else $error("strobe low during rewind");
  rewind_mode_a: assert property (
    $fell(st_q.rt_n) |-> !st_q.depth)
    else $error("rewind in depth mode");
  write_guard_a: assert property (
    $fell(st_q.wr_n) |-> $past(full_s) && $past(st_q.settled))
    else $error("write strobed while full");
  read_guard_a: assert property (
    $fell(st_q.rd_n) |-> $past(empty_s) && $past(st_q.settled))
    else $error("read strobed while empty");
  write_width_a: assert property (
    $fell(st_q.wr_n) |=> (!st_q.wr_n && $stable(st_q.din))[*8])
    else $error("write strobe too short");
  chain_single_a: assert property (
    !st_q.depth |-> !chain_in_n)
    else $error("chain input not low in single mode");
  init_settle_a: assert property (
    $rose(st_q.init_n) |-> !st_q.settled ##1 (!st_q.settled)[*8])
    else $error("settled too early after init");
  strobe_excl_a: assert property (
    !(!st_q.wr_n && !st_q.rd_n))
    else $error("read and write strobes low together");
  ack_pulse_a: assert property (
    !st_q.waitreq |=> st_q.waitreq)
    else $error("waitrequest low for more than one cycle");

endmodule

// >>> verilog/asf_pkg.sv
// Constants shared by the strobe FIFO host controller
package asf_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_MHZ = 250;
  localparam int T_STROBE_NS = 40;
  localparam int T_RECOVER_NS = 60;
  localparam int T_INIT_NS = 100;
  localparam int T_SETTLE_NS = 100;
  localparam int SYNC_LAT = 3;

  // Least times round up to whole cycles, never below one
  function automatic int asf_ns2cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [15:0] CYC_STROBE = 16'(asf_ns2cyc(T_STROBE_NS));
  localparam logic [15:0] CYC_RECOVER =
    16'(asf_ns2cyc(T_RECOVER_NS) + SYNC_LAT);
  localparam logic [15:0] CYC_INIT = 16'(asf_ns2cyc(T_INIT_NS));
  localparam logic [15:0] CYC_SETTLE =
    16'(asf_ns2cyc(T_SETTLE_NS) + SYNC_LAT);

  // ==========================================================
  // Register map, word index on address[3:2]
  localparam int ADDR_W = 4;
  localparam logic [1:0] REG_CFG = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_CMD = 2'h2;
  localparam logic [1:0] REG_DATA = 2'h3;

  // Field positions
  localparam int CFG_DEPTH = 0;
  localparam int CFG_LEAD = 1;
  localparam int CMD_INIT = 0;
  localparam int CMD_REWIND = 1;
  localparam int ST_EMPTY = 0;
  localparam int ST_FULL = 1;
  localparam int ST_HALF = 2;
  localparam int ST_REFUSED = 3;
  localparam int ST_SETTLED = 4;

  localparam int WORD_W = 9;
  localparam int FLAG_W = 3;

  typedef enum {
    S_IDLE, S_WLOW, S_RLOW, S_INIT, S_REWIND, S_REC, S_SETTLE, S_ACK
  } asf_state_e;

endpackage

// >>> verilog/asf_sync.sv
// Three-stage synchroniser for pin inputs, agreement-filtered
`timescale 1ns/1ps
module asf_sync #(
  parameter int W = 1
) (
  clk,
  rst_n,
  din,
  dout
);
  input wire logic clk;
  input wire logic rst_n;
  input wire logic [W-1:0] din;
  output logic [W-1:0] dout;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } asf_sync_s;

  asf_sync_s st_q;
  asf_sync_s st_d;

  // ==========================================================
  // Stage two and three agreeing per bit is a settled level
  always_comb begin
    st_d = st_q;
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.out[i] = st_q.s3[i];
      end
    end
  end

  // Reset to all ones: idle flags are high on the pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.out;

endmodule
